// ### hw/aux_readout.sv
// What this block does
// - Command 0x14 plus two bytes starts conversions
// - Channel byte: zeros, temp, supply, pin, select
// - Disabled channel skipped, result reads zero
// - Temperature channel converted into 16-bit result
// - Supply channel converted into 16-bit result
// - Pin select picks one of four pins
// - Time code sets conversion length; zero byte defaults
// - Low nibble sets pin attenuation, default 0xC
// - Reply: ready byte, pin, supply, temp, two reserved
// - Eleven converted bits in each result
// - Supply check only at enabled timer expiry
// - Threshold 1.5 V plus 50 mV steps
// - Low supply reported on interrupt or pin
// - Shutdown pin high resets everything
// - Interrupt pin low while enabled event stands
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`include "aux_params.svh"
`default_nettype none

module aux_readout #(
    parameter int ADDR_W = 8
) (
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire logic               shutdown_pin,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic               cmp_pin,
    output logic [`AUX_SAR_BITS-1:0] dac_code,
    output aux_pkg::aux_chan_e      analog_chan,
    output logic [1:0]              pin_sel,
    output logic [3:0]              pin_attenuation_code,
    input  wire logic               wakeup_timer_on,
    input  wire logic               wakeup_expire,
    output logic                    low_supply_pin,
    output logic                    interrupt_out_n
);

    aux_sar_if sar_bus ();

    // Shutdown high acts as reset; the host keeps it low otherwise
    wire areset_n = rst_n & ~shutdown_pin;

    aux_sar #(
        .BITS       (`AUX_SAR_BITS)
    ) u_sar (
        .clock      (clock),
        .rst_n      (areset_n),
        .clk_en     (clk_en),
        .cmp_pin    (cmp_pin),
        .dac_code   (dac_code),
        .sar        (sar_bus.conv)
    );

    aux_pkg::aux_state_e            st;
    logic                           launched;
    logic [7:0]                     chan_byte;
    logic [3:0]                     conversion_time_code;
    logic [`AUX_RESULT_W-1:0]       pin_res;
    logic [`AUX_RESULT_W-1:0]       supply_res;
    logic [`AUX_RESULT_W-1:0]       temp_res;
    logic [3:0]                     reply_idx;
    logic [`AUX_LSD_TH_W-1:0]       low_supply_threshold;
    logic                           wakeup_supply_check_on;
    logic                           low_supply_to_pin;
    logic                           lsd_pending;
    logic [`AUX_INT_W-1:0]          int_status;
    logic [`AUX_INT_W-1:0]          int_enable;
    logic                           dp_write;
    logic [ADDR_W-1:0]              dp_addr;
    logic                           cmd_done_pulse;
    logic                           lsd_low_pulse;
    logic [7:0]                     new_cfg_q;

    // Bus: zero wait states while enabled; a frozen block stalls the bus
    assign hreadyout = clk_en;
    assign hresp     = 1'b0;

    wire              ahb_go    = hsel && htrans[1] && hready;
    wire              ahb_rd    = ahb_go && !hwrite;
    wire [ADDR_W-1:0] a_addr    = haddr[ADDR_W-1:0];
    wire              wr_cmd    = dp_write && dp_addr == `AUX_REG_CMD;
    wire              wr_lsd    = dp_write && dp_addr == `AUX_REG_LSD_CFG;
    wire              wr_clr    = dp_write && dp_addr == `AUX_REG_INT_CLR;
    wire              wr_en     = dp_write && dp_addr == `AUX_REG_INT_EN;
    wire              rd_reply  = ahb_rd && a_addr == `AUX_REG_REPLY;

    // Command decode
    wire              cmd_ok    = hwdata[7:0] == `AUX_CMD_READ;
    wire              cmd_take  = wr_cmd && cmd_ok && st == aux_pkg::AUX_ST_IDLE;
    wire [7:0]        new_chan  = hwdata[15:8];
    wire [7:0]        new_cfg   = hwdata[23:16];
    wire              cfg_zero  = new_cfg == 8'h00;
    wire [3:0]        new_code  = cfg_zero ? `AUX_CFG_DEFAULT : new_cfg[7:4];
    wire [3:0]        new_att   = cfg_zero ? `AUX_ATT_DEFAULT : new_cfg[3:0];
    wire              busy      = st != aux_pkg::AUX_ST_IDLE && st != aux_pkg::AUX_ST_LSD;
    wire [7:0]        cts       = (busy || cmd_take) ? `AUX_CTS_BUSY : `AUX_CTS_DONE;

    // Channel enables; upper three bits must be zero
    wire              pin_on    = chan_byte[`AUX_CH_PIN];
    wire              supply_on = chan_byte[`AUX_CH_SUPPLY];
    wire              temp_on   = chan_byte[`AUX_CH_TEMP];
    wire              cur_on    = (st == aux_pkg::AUX_ST_PIN && pin_on) ||
                                  (st == aux_pkg::AUX_ST_SUPPLY && supply_on) ||
                                  (st == aux_pkg::AUX_ST_TEMP && temp_on) ||
                                  st == aux_pkg::AUX_ST_LSD;
    wire [`AUX_RESULT_W-1:0] conv_res = {{(`AUX_RESULT_W-`AUX_SAR_BITS){1'b0}},
                                          sar_bus.result};

    // Analog mux follows the sequencer
    assign analog_chan = (st == aux_pkg::AUX_ST_TEMP) ? aux_pkg::AUX_CHAN_TEMP :
                         (st == aux_pkg::AUX_ST_PIN)  ? aux_pkg::AUX_CHAN_PIN :
                                                        aux_pkg::AUX_CHAN_SUPPLY;
    assign pin_sel     = chan_byte[1:0];

    // Low-supply compare: 3*r < 1920 + 64*n, exact in result units
    wire [17:0] supply_x3 = {2'b00, conv_res} + {1'b0, conv_res, 1'b0};
    wire [17:0] th_units  = `AUX_LSD_BASE + `AUX_LSD_STEP * 18'(low_supply_threshold);
    wire        is_low    = supply_x3 < th_units;
    wire        lsd_trig  = wakeup_expire && wakeup_timer_on && wakeup_supply_check_on;

    function automatic logic [7:0] reply_byte(input logic [3:0] idx);
        unique case (idx)
            4'h0:    reply_byte = cts;
            4'h1:    reply_byte = pin_res[15:8];
            4'h2:    reply_byte = pin_res[7:0];
            4'h3:    reply_byte = supply_res[15:8];
            4'h4:    reply_byte = supply_res[7:0];
            4'h5:    reply_byte = temp_res[15:8];
            4'h6:    reply_byte = temp_res[7:0];
            default: reply_byte = 8'h00;
        endcase
    endfunction

    wire [31:0] rd_mux =
        (a_addr == `AUX_REG_CMD)      ? {8'h00, new_cfg_q, chan_byte, `AUX_CMD_READ} :
        (a_addr == `AUX_REG_CTS)      ? {24'h000000, cts} :
        (a_addr == `AUX_REG_PIN)      ? {16'h0000, pin_res} :
        (a_addr == `AUX_REG_SUPPLY)   ? {16'h0000, supply_res} :
        (a_addr == `AUX_REG_TEMP)     ? {16'h0000, temp_res} :
        (a_addr == `AUX_REG_REPLY)    ? {24'h000000, reply_byte(busy ? 4'h0 : reply_idx)} :
        (a_addr == `AUX_REG_LSD_CFG)  ? {22'h000000, low_supply_to_pin,
                                         wakeup_supply_check_on, 3'h0, low_supply_threshold} :
        (a_addr == `AUX_REG_INT_STAT) ? {30'h00000000, int_status} :
        (a_addr == `AUX_REG_INT_EN)   ? {30'h00000000, int_enable} :
                                        32'h00000000;

    assign new_cfg_q           = {conversion_time_code, pin_attenuation_code};
    assign sar_bus.time_code   = conversion_time_code;

    always_ff @(posedge clock or negedge areset_n)
    begin
        if (!areset_n)
        begin
            dp_write <= 1'b0;
            dp_addr  <= '0;
            hrdata   <= 32'h00000000;
        end
        else if (clk_en)
        begin
            dp_write <= ahb_go && hwrite;
            dp_addr  <= a_addr;
            if (ahb_rd)
                hrdata <= rd_mux;
        end
    end

    // Reply walk: stays on the ready byte while busy so the host can retry
    always_ff @(posedge clock or negedge areset_n)
    begin
        if (!areset_n)
            reply_idx <= 4'h0;
        else if (clk_en)
        begin
            if (cmd_take)
                reply_idx <= 4'h0;
            else if (rd_reply && !busy)
                reply_idx <= (reply_idx == `AUX_REPLY_LAST) ? 4'h0 : reply_idx + 4'h1;
        end
    end

    // Sequencer: pin, supply, temperature; supply checks run when idle
    always_ff @(posedge clock or negedge areset_n)
    begin
        if (!areset_n)
        begin
            st                   <= aux_pkg::AUX_ST_IDLE;
            launched             <= 1'b0;
            sar_bus.start        <= 1'b0;
            chan_byte            <= 8'h00;
            conversion_time_code <= `AUX_CFG_DEFAULT;
            pin_attenuation_code <= `AUX_ATT_DEFAULT;
            pin_res              <= '0;
            supply_res           <= '0;
            temp_res             <= '0;
            cmd_done_pulse       <= 1'b0;
            lsd_low_pulse        <= 1'b0;
            low_supply_pin       <= 1'b0;
        end
        else if (clk_en)
        begin
            sar_bus.start  <= 1'b0;
            cmd_done_pulse <= 1'b0;
            lsd_low_pulse  <= 1'b0;
            unique case (st)
                aux_pkg::AUX_ST_IDLE:
                begin
                    if (cmd_take)
                    begin
                        chan_byte            <= new_chan;
                        conversion_time_code <= new_code;
                        pin_attenuation_code <= new_att;
                        st                   <= aux_pkg::AUX_ST_PIN;
                    end
                    else if (lsd_pending)
                    begin
                        // Check reuses the last command's time code to stay short
                        st <= aux_pkg::AUX_ST_LSD;
                    end
                end
                default:
                begin
                    if (!cur_on)
                    begin
                        // Skipped channel reads back as zero
                        unique case (st)
                            aux_pkg::AUX_ST_PIN:    pin_res    <= '0;
                            aux_pkg::AUX_ST_SUPPLY: supply_res <= '0;
                            default:                temp_res   <= '0;
                        endcase
                        st <= next_state(st);
                    end
                    else if (!launched)
                    begin
                        sar_bus.start <= 1'b1;
                        launched      <= 1'b1;
                    end
                    else if (sar_bus.done)
                    begin
                        launched <= 1'b0;
                        unique case (st)
                            aux_pkg::AUX_ST_PIN:    pin_res    <= conv_res;
                            aux_pkg::AUX_ST_SUPPLY: supply_res <= conv_res;
                            aux_pkg::AUX_ST_TEMP:   temp_res   <= conv_res;
                            default:
                            begin
                                if (low_supply_to_pin)
                                    low_supply_pin <= is_low;
                                else
                                    lsd_low_pulse  <= is_low;
                            end
                        endcase
                        cmd_done_pulse <= st == aux_pkg::AUX_ST_TEMP;
                        st             <= next_state(st);
                    end
                end
            endcase
            if (st == aux_pkg::AUX_ST_TEMP && !temp_on)
                cmd_done_pulse <= 1'b1;
        end
    end

    function automatic aux_pkg::aux_state_e next_state(input aux_pkg::aux_state_e s);
        unique case (s)
            aux_pkg::AUX_ST_PIN:    next_state = aux_pkg::AUX_ST_SUPPLY;
            aux_pkg::AUX_ST_SUPPLY: next_state = aux_pkg::AUX_ST_TEMP;
            default:                next_state = aux_pkg::AUX_ST_IDLE;
        endcase
    endfunction

    // Low-supply config and pending check; a new expiry wins over the take
    always_ff @(posedge clock or negedge areset_n)
    begin
        if (!areset_n)
        begin
            low_supply_threshold   <= '0;
            wakeup_supply_check_on <= 1'b0;
            low_supply_to_pin      <= 1'b0;
            lsd_pending            <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_lsd)
            begin
                low_supply_threshold   <= hwdata[`AUX_LSD_TH_W-1:0];
                wakeup_supply_check_on <= hwdata[`AUX_LSD_CHECK_BIT];
                low_supply_to_pin      <= hwdata[`AUX_LSD_GPIO_BIT];
            end
            if (lsd_trig)
                lsd_pending <= 1'b1;
            else if (st == aux_pkg::AUX_ST_IDLE && !cmd_take)
                lsd_pending <= 1'b0;
        end
    end

    // Interrupts: sticky status, set wins over clear
    wire [`AUX_INT_W-1:0] int_set = {lsd_low_pulse, cmd_done_pulse};

    always_ff @(posedge clock or negedge areset_n)
    begin
        if (!areset_n)
        begin
            int_status <= '0;
            int_enable <= '0;
        end
        else if (clk_en)
        begin
            int_status <= (int_status & ~(wr_clr ? hwdata[`AUX_INT_W-1:0] : '0)) | int_set;
            if (wr_en)
                int_enable <= hwdata[`AUX_INT_W-1:0];
        end
    end

    assign interrupt_out_n = ~|(int_status & int_enable);

    sequence s_cmd_taken;
        clk_en && cmd_take;
    endsequence

    sequence s_low_seen;
        clk_en && st == aux_pkg::AUX_ST_LSD && launched && sar_bus.done && is_low &&
        !low_supply_to_pin;
    endsequence

    a_cmd_starts: assert property (@(posedge clock) disable iff (!areset_n)
        s_cmd_taken |=> st == aux_pkg::AUX_ST_PIN && cts == `AUX_CTS_BUSY)
        else $error("read command did not start the sequence");

    a_cfg_default: assert property (@(posedge clock) disable iff (!areset_n)
        s_cmd_taken and cfg_zero |=> conversion_time_code == `AUX_CFG_DEFAULT &&
        pin_attenuation_code == `AUX_ATT_DEFAULT)
        else $error("zero config byte did not default");

    a_skip_zero: assert property (@(posedge clock) disable iff (!areset_n)
        clk_en && st == aux_pkg::AUX_ST_SUPPLY && !supply_on |=>
        supply_res == '0 && st == aux_pkg::AUX_ST_TEMP)
        else $error("skipped channel not zero");

    a_result_width: assert property (@(posedge clock) disable iff (!areset_n)
        pin_res[15:11] == 5'h00 && supply_res[15:11] == 5'h00 && temp_res[15:11] == 5'h00)
        else $error("result above eleven bits");

    a_reply_order: assert property (@(posedge clock) disable iff (!areset_n)
        clk_en && rd_reply && !busy && reply_idx == 4'h3 |=> hrdata[7:0] == supply_res[15:8])
        else $error("reply byte out of order");

    a_lsd_gated: assert property (@(posedge clock) disable iff (!areset_n)
        $rose(st == aux_pkg::AUX_ST_LSD) |-> $past(lsd_pending) && !$past(cmd_take))
        else $error("supply check without timer expiry");

    a_low_irq: assert property (@(posedge clock) disable iff (!areset_n)
        s_low_seen ##1 clk_en |=> int_status[`AUX_INT_LOW])
        else $error("low supply not flagged");

    a_irq_pin: assert property (@(posedge clock) disable iff (!areset_n)
        s_low_seen ##1 clk_en && int_enable[`AUX_INT_LOW] && !wr_clr |=> !interrupt_out_n)
        else $error("interrupt pin not low");

    a_shutdown: assert property (@(posedge clock) disable iff (!rst_n)
        shutdown_pin |-> st == aux_pkg::AUX_ST_IDLE && int_status == '0 && interrupt_out_n)
        else $error("shutdown did not reset");

endmodule // aux_readout

`default_nettype wire

// ### common/aux_params.svh
`ifndef AUX_PARAMS_SVH
`define AUX_PARAMS_SVH

// Converter shape
`define AUX_SAR_BITS        11
`define AUX_RESULT_W        16
`define AUX_PHASES          12
`define AUX_TICK_W          17
`define AUX_CONV_CNT_W      21

// Command stream
`define AUX_CMD_READ        8'h14
`define AUX_CFG_DEFAULT     4'hC
`define AUX_ATT_DEFAULT     4'hC
`define AUX_CH_TEMP         4
`define AUX_CH_SUPPLY       3
`define AUX_CH_PIN          2
`define AUX_CH_ZERO_MSB     7
`define AUX_CH_ZERO_LSB     5

// Reply stream
`define AUX_CTS_DONE        8'hFF
`define AUX_CTS_BUSY        8'h00
`define AUX_REPLY_LAST      4'h8

// Low-supply threshold: 3*result < BASE + STEP*code
`define AUX_LSD_TH_W        5
`define AUX_LSD_BASE        18'h00780
`define AUX_LSD_STEP        18'h00040
`define AUX_LSD_CHECK_BIT   8
`define AUX_LSD_GPIO_BIT    9

// Interrupt bits
`define AUX_INT_DONE        0
`define AUX_INT_LOW         1
`define AUX_INT_W           2

// Register byte offsets
`define AUX_REG_CMD         8'h00
`define AUX_REG_CTS         8'h04
`define AUX_REG_PIN         8'h08
`define AUX_REG_SUPPLY      8'h0C
`define AUX_REG_TEMP        8'h10
`define AUX_REG_RSVD        8'h14
`define AUX_REG_REPLY       8'h18
`define AUX_REG_LSD_CFG     8'h20
`define AUX_REG_INT_STAT    8'h24
`define AUX_REG_INT_CLR     8'h28
`define AUX_REG_INT_EN      8'h2C

`endif

// ### common/aux_pkg.sv
`default_nettype none

package aux_pkg;

    typedef enum logic [4:0] {
        AUX_ST_IDLE   = 5'b00001,
        AUX_ST_PIN    = 5'b00010,
        AUX_ST_SUPPLY = 5'b00100,
        AUX_ST_TEMP   = 5'b01000,
        AUX_ST_LSD    = 5'b10000
    } aux_state_e;

    typedef enum logic [1:0] {
        AUX_CHAN_PIN    = 2'h0,
        AUX_CHAN_SUPPLY = 2'h1,
        AUX_CHAN_TEMP   = 2'h2
    } aux_chan_e;

endpackage : aux_pkg

`default_nettype wire

// ### common/aux_sar_if.sv
`include "aux_params.svh"
`default_nettype none

interface aux_sar_if;
    logic                       start;
    logic [3:0]                 time_code;
    logic                       done;
    logic [`AUX_SAR_BITS-1:0]   result;

    modport ctrl (output start, output time_code, input done, input result);
    modport conv (input start, input time_code, output done, output result);
endinterface : aux_sar_if

`default_nettype wire

// ### hw/aux_sar.sv
`include "aux_params.svh"
`default_nettype none

module aux_sar #(
    parameter int BITS = `AUX_SAR_BITS
) (
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire logic               cmp_pin,
    output logic [BITS-1:0]         dac_code,
    aux_sar_if.conv                 sar
);

    logic                           cmp_meta;
    logic                           cmp_sync;
    logic [`AUX_TICK_W-1:0]         tick;
    logic [3:0]                     bit_idx;
    logic                           busy;
    logic                           sampling;
    logic [`AUX_CONV_CNT_W-1:0]     conv_cnt;

    // One sample phase then one phase per bit, each 2^(code+1) clocks
    // Code 0 phases are shorter than the comparator sync delay, so resolution drops
    wire [`AUX_TICK_W-1:0] step_last = (`AUX_TICK_W'(2) << sar.time_code) - `AUX_TICK_W'(1);
    wire                   step_end  = busy && (tick == step_last);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end
        else if (clk_en)
        begin
            cmp_meta <= cmp_pin;
            cmp_sync <= cmp_meta;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy       <= 1'b0;
            sampling   <= 1'b0;
            tick       <= '0;
            bit_idx    <= '0;
            dac_code   <= '0;
            sar.done   <= 1'b0;
            sar.result <= '0;
        end
        else if (clk_en)
        begin
            sar.done <= 1'b0;
            tick     <= step_end ? '0 : tick + `AUX_TICK_W'(1);
            if (sar.start && !busy)
            begin
                busy     <= 1'b1;
                sampling <= 1'b1;
                tick     <= '0;
                bit_idx  <= 4'(BITS - 1);
                dac_code <= '0;
            end
            else if (step_end && sampling)
            begin
                sampling          <= 1'b0;
                dac_code[bit_idx] <= 1'b1;
            end
            else if (step_end)
            begin
                // Keep the trial bit while the input stands above the trial level
                dac_code[bit_idx] <= cmp_sync;
                if (bit_idx != 4'h0)
                begin
                    dac_code[bit_idx - 4'h1] <= 1'b1;
                    bit_idx                  <= bit_idx - 4'h1;
                end
                else
                begin
                    busy       <= 1'b0;
                    sar.done   <= 1'b1;
                    sar.result <= {dac_code[BITS-1:1], cmp_sync};
                end
            end
        end
    end

    // Helper count for the conversion-time check
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            conv_cnt <= '0;
        else if (clk_en)
            conv_cnt <= (sar.start && !busy) ? '0 : conv_cnt + `AUX_CONV_CNT_W'(1);
    end

    a_conv_time: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(sar.done) |-> conv_cnt == `AUX_CONV_CNT_W'(`AUX_PHASES << (sar.time_code + 1)))
        else $error("conversion length does not match time code");

endmodule // aux_sar

`default_nettype wire

// ### verif/aux_front_model.sv
`default_nettype none

module aux_front_model
(
    input  wire logic [10:0]        dac_code,
    input  wire aux_pkg::aux_chan_e analog_chan,
    input  wire logic [1:0]         pin_sel,
    output logic                    cmp_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each pin gets its own level so a wrong select shows up
    wire logic [10:0] level = (analog_chan == aux_pkg::AUX_CHAN_TEMP) ? 11'h3A5 :
        (analog_chan == aux_pkg::AUX_CHAN_SUPPLY) ? 11'h500 : {2'h1, pin_sel, 7'h11};
    assign cmp_pin = level > dac_code;
endmodule // aux_front_model

`default_nettype wire

// ### verif/test_aux_readout.sv
`include "aux_params.svh"
`default_nettype none

module test_aux_readout;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_n = 0, clk_en = 1, shutdown_pin = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, q;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic wakeup_timer_on = 0, wakeup_expire = 0;
    logic [7:0] r [9];
    logic [7:0] ch [3] = '{8'h10, 8'hE8, 8'h06};
    wire logic hreadyout, hresp, cmp_pin, low_supply_pin, interrupt_out_n;
    wire logic [31:0] hrdata;
    wire logic [10:0] dac_code;
    wire aux_pkg::aux_chan_e analog_chan;
    wire logic [1:0] pin_sel;
    wire logic [3:0] pin_attenuation_code;
    int n_fail = 0, checks = 0, t0, t1;

    always #12.5 clock = ~clock;

    aux_readout i_aux_readout (.clock, .rst_n, .clk_en, .shutdown_pin, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .cmp_pin, .dac_code, .analog_chan, .pin_sel, .pin_attenuation_code,
        .wakeup_timer_on, .wakeup_expire, .low_supply_pin, .interrupt_out_n);
    aux_front_model i_aux_front_model (.dac_code, .analog_chan, .pin_sel, .cmp_pin);

    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // SAR rounding at the last step is loose, so one code either way
    task automatic near(input logic [31:0] g, input logic [31:0] e);
        chk((e != 0 && (g + 32'h1 - e) <= 32'h2) ? e : g, e);
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 200);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 200);
        q = hrdata;
        if (n >= 200)
        begin
            n_fail++;
            wrap_up();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(q, e);
    endtask

    task automatic wait_irq(output int c);
        c = 0;
        while (interrupt_out_n !== 1'b0 && c < 3000)
        begin
            @(posedge clock);
            c++;
        end
        if (c >= 3000)
        begin
            n_fail++;
            wrap_up();
        end
    endtask

    task automatic expire();
        wakeup_expire <= 1'b1;
        @(posedge clock);
        wakeup_expire <= 1'b0;
    endtask

    task automatic cmd(input logic [7:0] c, input logic [7:0] f, output int t);
        bus(`AUX_REG_CMD, 1'b1, {8'h0, f, c, `AUX_CMD_READ});
        wait_irq(t);
    endtask

    initial
    begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(`AUX_REG_INT_STAT, 32'h0);
        chk({31'h0, interrupt_out_n}, 32'h1);
        bus(8'h40, 1'b1, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0);
        bus(`AUX_REG_INT_EN, 1'b1, 32'h1);
        cmd(8'h1D, 8'h14, t0);
        for (int i = 0; i < 9; i++)
        begin
            bus(`AUX_REG_REPLY, 1'b0, 32'h0);
            r[i] = q[7:0];
        end
        chk({24'h0, r[0]}, {24'h0, `AUX_CTS_DONE});
        near({16'h0, r[1], r[2]}, 32'h291);
        near({16'h0, r[3], r[4]}, 32'h500);
        near({16'h0, r[5], r[6]}, 32'h3A5);
        chk({16'h0, r[7], r[8]}, 32'h0);
        chk({28'h0, pin_attenuation_code}, 32'h4);
        chk({31'h0, interrupt_out_n}, 32'h0);
        bus(`AUX_REG_INT_CLR, 1'b1, 32'h1);
        rd(`AUX_REG_INT_STAT, 32'h0);
        chk({31'h0, interrupt_out_n}, 32'h1);
        foreach (ch[k])
        begin
            cmd(ch[k], 8'h18, t0);
            bus(`AUX_REG_INT_CLR, 1'b1, 32'h1);
            bus(`AUX_REG_PIN, 1'b0, 32'h0);
            near(q, ch[k][2] ? {21'h0, 2'h1, ch[k][1:0], 7'h11} : 32'h0);
            bus(`AUX_REG_SUPPLY, 1'b0, 32'h0);
            near(q, ch[k][3] ? 32'h500 : 32'h0);
            bus(`AUX_REG_TEMP, 1'b0, 32'h0);
            near(q, ch[k][4] ? 32'h3A5 : 32'h0);
        end
        cmd(8'h10, 8'h08, t0);
        bus(`AUX_REG_INT_CLR, 1'b1, 32'h1);
        cmd(8'h10, 8'h18, t1);
        chk(t1 - t0, 32'd24);
        bus(`AUX_REG_INT_CLR, 1'b1, 32'h1);
        bus(`AUX_REG_CMD, 1'b1, 32'h0004_1D15);
        rd(`AUX_REG_CTS, {24'h0, `AUX_CTS_DONE});
        bus(`AUX_REG_CMD, 1'b1, 32'h0004_1014);
        rd(`AUX_REG_CTS, {24'h0, `AUX_CTS_BUSY});
        clk_en <= 1'b0;
        repeat (3) @(posedge clock);
        chk({31'h0, hreadyout}, 32'h0);
        clk_en <= 1'b1;
        wait_irq(t0);
        bus(`AUX_REG_LSD_CFG, 1'b1, 32'h11F);
        bus(`AUX_REG_CMD, 1'b1, 32'h0000_1014);
        rd(`AUX_REG_CMD, 32'h00CC_1014);
        chk({28'h0, pin_attenuation_code}, {28'h0, `AUX_ATT_DEFAULT});
        shutdown_pin <= 1'b1;
        repeat (2) @(posedge clock);
        shutdown_pin <= 1'b0;
        @(posedge clock);
        rd(`AUX_REG_LSD_CFG, 32'h0);
        rd(`AUX_REG_INT_EN, 32'h0);
        chk({31'h0, low_supply_pin}, 32'h0);
        bus(`AUX_REG_INT_EN, 1'b1, 32'h3);
        bus(`AUX_REG_LSD_CFG, 1'b1, 32'h11F);
        expire();
        cmd(8'h10, 8'h18, t0);
        rd(`AUX_REG_INT_STAT, 32'h1);
        bus(`AUX_REG_INT_CLR, 1'b1, 32'h3);
        wakeup_timer_on <= 1'b1;
        expire();
        wait_irq(t0);
        rd(`AUX_REG_INT_STAT, 32'h2);
        bus(`AUX_REG_INT_CLR, 1'b1, 32'h3);
        bus(`AUX_REG_LSD_CFG, 1'b1, 32'h31F);
        expire();
        repeat (60) @(posedge clock);
        chk({31'h0, low_supply_pin}, 32'h1);
        bus(`AUX_REG_LSD_CFG, 1'b1, 32'h300);
        expire();
        repeat (60) @(posedge clock);
        chk({31'h0, low_supply_pin}, 32'h0);
        rd(`AUX_REG_INT_STAT, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        wrap_up();
    end
endmodule // test_aux_readout

`default_nettype wire
